/* File: design/disp_write_defines.vh */
`ifndef DISP_WRITE_DEFINES_VH
`define DISP_WRITE_DEFINES_VH

// =====================================================================
// control word field positions
`define CW_BURST_BIT 7
`define CW_FONT_BIT 6
`define CW_NODEC_BIT 5
`define CW_RUN_BIT 4
`define CW_BANK_BIT 3
`define CW_ADDR_MSB 2
`define CW_ADDR_LSB 0

// =====================================================================
// reset values and sizes
`define CW_RESET 8'h10
`define DIGIT_COUNT 4'h8
`define BURST_LAST 3'h7
`define SYNC_WIDTH 10

`endif

/* File: design/pin_sync3.v */
`timescale 1ns/1ns

// =====================================================================
// three-stage pin synchroniser with agreement filter
module pin_sync3 #(
  parameter WIDTH = 10
) (
  // clock and reset
  input wire clk,
  input wire resetn,
  // pin side
  input wire [WIDTH-1:0] pin_in,
  // clock domain side
  output wire [WIDTH-1:0] pin_stable
);

  genvar gi;

  // one chain per bit; stage one feeds stage two only
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg stable_r;
      always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
          stable_r <= 1'b0;
        end else begin
          s1_r <= pin_in[gi];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            stable_r <= s3_r; // change counts once two stages agree
          end
        end
      end
      assign pin_stable[gi] = stable_r;
    end
  endgenerate

endmodule

/* File: design/display_driver_write_port.v */
`timescale 1ns/1ns
`include "disp_write_defines.vh"

// Contract
// - mode high loads control, low loads RAM
// - control line four low shuts display down
// - data lines zero to six are bits one-seven
// - burst flag low: lines two-zero address digit
// - line three picks bank A/B, decode only
// - line six high hex font, low BCD
// - line five high selects no-decode segments
// - capture on rising edge of write strobe
// - line seven high announces sequential data
// - data line seven is decimal point bit
module display_driver_write_port (
  // clock and reset
  input wire clk,
  input wire resetn,
  // host bus pins
  input wire host_bus_line0,
  input wire host_bus_line1,
  input wire host_bus_line2,
  input wire host_bus_line3,
  input wire host_bus_line4,
  input wire host_bus_line5,
  input wire host_bus_line6,
  input wire host_bus_line7,
  input wire mode_select,
  input wire write_strobe,
  // digit view, same clock domain
  input wire [2:0] view_digit,
  // control state
  output reg [7:0] control_word_r,
  output reg font_select_r,
  output reg no_decode_r,
  output reg display_on_r,
  output reg bank_a_r,
  output reg burst_busy_r,
  // decoded view of one digit: dp, g..a
  output reg [7:0] view_segments_r
);

  // ===================================================================
  // pin synchronisation
  wire [9:0] pins_raw;
  wire [9:0] pins_s;
  wire [7:0] bus_s;
  wire mode_s;
  wire wr_s;

  assign pins_raw = {write_strobe, mode_select, host_bus_line7, host_bus_line6,
                     host_bus_line5, host_bus_line4, host_bus_line3,
                     host_bus_line2, host_bus_line1, host_bus_line0};

  pin_sync3 #(
    .WIDTH(`SYNC_WIDTH)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .pin_in(pins_raw),
    .pin_stable(pins_s)
  );

  assign bus_s = pins_s[7:0];
  assign mode_s = pins_s[8];
  assign wr_s = pins_s[9];

  // ===================================================================
  // write strobe edge detection
  reg wr_d_r;
  wire wr_rise;

  // bus and strobe share the pipeline, so data seen here matches the edge
  assign wr_rise = wr_s & ~wr_d_r;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_d_r <= 1'b0;
    end else begin
      wr_d_r <= wr_s;
    end
  end

  // ===================================================================
  // entry state machine
  localparam ST_SINGLE = 2'b00;
  localparam ST_BURST = 2'b01;
  localparam ST_IDLE = 2'b10;

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [2:0] wr_ptr_r;
  reg [2:0] wr_ptr_nxt;
  reg ctrl_wr;
  reg ram_wr;

  // route each captured write and advance the digit pointer
  always @* begin
    state_nxt = state_r;
    wr_ptr_nxt = wr_ptr_r;
    ctrl_wr = 1'b0;
    ram_wr = 1'b0;
    if (wr_rise) begin
      if (mode_s) begin
        ctrl_wr = 1'b1;
        if (bus_s[`CW_BURST_BIT]) begin
          state_nxt = ST_BURST;
          wr_ptr_nxt = 3'h0;
        end else begin
          state_nxt = ST_SINGLE;
          wr_ptr_nxt = bus_s[`CW_ADDR_MSB:`CW_ADDR_LSB];
        end
      end else begin
        case (state_r)
          ST_BURST: begin
            ram_wr = 1'b1;
            if (wr_ptr_r == `BURST_LAST) begin
              state_nxt = ST_IDLE;
            end else begin
              wr_ptr_nxt = wr_ptr_r + 3'h1;
            end
          end
          ST_SINGLE: begin
            ram_wr = 1'b1;
          end
          default: begin
            ram_wr = 1'b0; // burst complete, extra data dropped
          end
        endcase
      end
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_SINGLE;
      wr_ptr_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      wr_ptr_r <= wr_ptr_nxt;
    end
  end

  // ===================================================================
  // control word and decoded fields
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      control_word_r <= `CW_RESET;
      font_select_r <= 1'b0;
      no_decode_r <= 1'b0;
      display_on_r <= 1'b1;
      bank_a_r <= 1'b0;
      burst_busy_r <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        control_word_r <= bus_s;
        font_select_r <= bus_s[`CW_FONT_BIT];
        no_decode_r <= bus_s[`CW_NODEC_BIT];
        display_on_r <= bus_s[`CW_RUN_BIT];
        bank_a_r <= bus_s[`CW_BANK_BIT];
      end
      burst_busy_r <= (state_nxt == ST_BURST);
    end
  end

  // ===================================================================
  // display RAM: two banks of eight digit bytes
  reg [7:0] ram_a [0:7];
  reg [7:0] ram_b [0:7];
  wire wr_bank_a;
  integer i;

  // no-decode always works on bank A
  assign wr_bank_a = bank_a_r | no_decode_r;

  // byte bit n holds data bit n+1, top bit is the decimal point
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (i = 0; i < 8; i = i + 1) begin
        ram_a[i] <= 8'h00;
        ram_b[i] <= 8'h00;
      end
    end else if (ram_wr) begin
      if (wr_bank_a) begin
        ram_a[wr_ptr_r] <= bus_s;
      end else begin
        ram_b[wr_ptr_r] <= bus_s;
      end
    end
  end

  // ===================================================================
  // character fonts, segments g..a
  function [6:0] hex_font;
    input [3:0] code;
    begin
      case (code)
        4'h0: hex_font = 7'h3f;
        4'h1: hex_font = 7'h06;
        4'h2: hex_font = 7'h5b;
        4'h3: hex_font = 7'h4f;
        4'h4: hex_font = 7'h66;
        4'h5: hex_font = 7'h6d;
        4'h6: hex_font = 7'h7d;
        4'h7: hex_font = 7'h07;
        4'h8: hex_font = 7'h7f;
        4'h9: hex_font = 7'h6f;
        4'ha: hex_font = 7'h77;
        4'hb: hex_font = 7'h7c;
        4'hc: hex_font = 7'h39;
        4'hd: hex_font = 7'h5e;
        4'he: hex_font = 7'h79;
        default: hex_font = 7'h71;
      endcase
    end
  endfunction

  // digits, then dash, E, H, L, P and blank
  function [6:0] bcd_font;
    input [3:0] code;
    begin
      case (code)
        4'ha: bcd_font = 7'h40;
        4'hb: bcd_font = 7'h79;
        4'hc: bcd_font = 7'h76;
        4'hd: bcd_font = 7'h38;
        4'he: bcd_font = 7'h73;
        4'hf: bcd_font = 7'h00;
        default: bcd_font = hex_font(code);
      endcase
    end
  endfunction

  // ===================================================================
  // digit view: picks bank and translation from the control word
  reg [7:0] view_byte;
  reg [7:0] view_nxt;

  always @* begin
    if (bank_a_r | no_decode_r) begin
      view_byte = ram_a[view_digit];
    end else begin
      view_byte = ram_b[view_digit];
    end
    if (!display_on_r) begin
      view_nxt = 8'h00;
    end else if (no_decode_r) begin
      view_nxt = view_byte;
    end else if (font_select_r) begin
      view_nxt = {view_byte[7], hex_font(view_byte[3:0])};
    end else begin
      view_nxt = {view_byte[7], bcd_font(view_byte[3:0])};
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      view_segments_r <= 8'h00;
    end else begin
      view_segments_r <= view_nxt;
    end
  end

endmodule

/* File: test/host_model.sv */
`timescale 1ns/1ns

// =====================================================================
// microprocessor side of the write port
module host_model (
  // clock
  input wire clk,
  // host pins
  output logic [7:0] bus,
  output logic mode,
  output logic strobe
);
  // one write: setup, strobe pulse, then bus and mode inverted
  task wr(input logic m, input logic [7:0] d);
    begin
      @(negedge clk);
      mode = m;
      bus = d;
      repeat (6) @(negedge clk);
      strobe = 1'b1;
      repeat (5) @(negedge clk);
      strobe = 1'b0;
      @(negedge clk);
      bus = ~d;
      mode = ~m;
      repeat (4) @(negedge clk);
    end
  endtask

  // idle levels at time zero
  initial begin
    bus = 8'h00;
    mode = 1'b0;
    strobe = 1'b0;
  end
endmodule

/* File: test/write_port_asserts.sv */
`timescale 1ns/1ns

// =====================================================================
// port-level checks of the write port
module write_port_asserts (
  input wire clk,
  input wire resetn,
  input wire host_bus_line0,
  input wire host_bus_line1,
  input wire host_bus_line2,
  input wire host_bus_line3,
  input wire host_bus_line4,
  input wire host_bus_line5,
  input wire host_bus_line6,
  input wire host_bus_line7,
  input wire mode_select,
  input wire write_strobe,
  input wire [7:0] control_word_r,
  input wire font_select_r,
  input wire no_decode_r,
  input wire display_on_r,
  input wire bank_a_r,
  input wire burst_busy_r,
  input wire [7:0] view_segments_r
);
  // bus lines gathered, line zero lowest
  wire [7:0] bus_w = {host_bus_line7, host_bus_line6, host_bus_line5, host_bus_line4,
    host_bus_line3, host_bus_line2, host_bus_line1, host_bus_line0};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_font_field: assert property (font_select_r == control_word_r[6])
    else $error("font flag differs from control word");
  a_nodec_field: assert property (no_decode_r == control_word_r[5])
    else $error("no-decode flag differs from control word");
  a_run_field: assert property (display_on_r == control_word_r[4])
    else $error("power flag differs from control word");
  a_bank_field: assert property (bank_a_r == control_word_r[3])
    else $error("bank flag differs from control word");
  a_blank_off: assert property (!display_on_r ##1 !display_on_r |-> view_segments_r == 8'h00)
    else $error("segments lit in shutdown");
  a_cw_mode: assert property ($changed(control_word_r) |->
    $past(mode_select, 4) && $past(write_strobe, 4))
    else $error("control word changed without control write");
  a_cw_value: assert property ($changed(control_word_r) |-> control_word_r == $past(bus_w, 4))
    else $error("control word not the captured bus");
  a_burst_none: assert property (!control_word_r[7] |-> !burst_busy_r)
    else $error("burst busy without burst flag");
endmodule

bind display_driver_write_port write_port_asserts chk_i (.clk(clk), .resetn(resetn),
  .host_bus_line0(host_bus_line0), .host_bus_line1(host_bus_line1),
  .host_bus_line2(host_bus_line2), .host_bus_line3(host_bus_line3),
  .host_bus_line4(host_bus_line4), .host_bus_line5(host_bus_line5),
  .host_bus_line6(host_bus_line6), .host_bus_line7(host_bus_line7),
  .mode_select(mode_select), .write_strobe(write_strobe), .control_word_r(control_word_r),
  .font_select_r(font_select_r), .no_decode_r(no_decode_r), .display_on_r(display_on_r),
  .bank_a_r(bank_a_r), .burst_busy_r(burst_busy_r), .view_segments_r(view_segments_r));

/* File: test/display_driver_write_port_bench.sv */
`timescale 1ns/1ns

// =====================================================================
// bench for the display write port
module display_driver_write_port_bench;
  logic clk, resetn;
  logic [2:0] view_digit;
  wire [7:0] bus, control_word_r, view_segments_r;
  wire mode, strobe, font_select_r, no_decode_r, display_on_r, bank_a_r, burst_busy_r;
  wire [7:0] flags = {3'h0, font_select_r, no_decode_r, display_on_r, bank_a_r, burst_busy_r};
  int n_errors = 0;
  int samples_checked = 0;
  logic [7:0] cw [3] = '{8'h5b, 8'h6c, 8'h27};

  host_model host (.clk(clk), .bus(bus), .mode(mode), .strobe(strobe));
  display_driver_write_port uut (.clk(clk), .resetn(resetn), .host_bus_line0(bus[0]),
    .host_bus_line1(bus[1]), .host_bus_line2(bus[2]), .host_bus_line3(bus[3]),
    .host_bus_line4(bus[4]), .host_bus_line5(bus[5]), .host_bus_line6(bus[6]),
    .host_bus_line7(bus[7]), .mode_select(mode), .write_strobe(strobe),
    .view_digit(view_digit), .control_word_r(control_word_r), .font_select_r(font_select_r),
    .no_decode_r(no_decode_r), .display_on_r(display_on_r), .bank_a_r(bank_a_r),
    .burst_busy_r(burst_busy_r), .view_segments_r(view_segments_r));

  // compare and count
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    begin
      samples_checked++;
      if (seen !== exp) begin
        n_errors++;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // pick a digit and look at its segments
  task view(input logic [2:0] d, input logic [7:0] e);
    begin
      @(negedge clk);
      view_digit = d;
      repeat (2) @(negedge clk);
      chk(view_segments_r, e);
    end
  endtask

  // verdict and end of run
  task finish_test;
    begin
      if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask

  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // watchdog
  initial begin
    #200000;
    n_errors++;
    finish_test();
  end

  // test sequence
  initial begin
    resetn = 1'b0;
    view_digit = 3'h0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    chk(control_word_r, 8'h10);
    chk(flags, 8'h04);
    foreach (cw[i]) begin
      host.wr(1'b1, cw[i]);
      chk(control_word_r, cw[i]);
      chk(flags, {3'h0, cw[i][6:3], 1'b0});
    end
    host.wr(1'b1, 8'h32);
    host.wr(1'b0, 8'ha5);
    chk(control_word_r, 8'h32);
    view(3'h2, 8'ha5);
    view(3'h1, 8'h00);
    host.wr(1'b1, 8'hb0);
    chk(burst_busy_r, 8'h01);
    for (int i = 0; i < 8; i++) host.wr(1'b0, 8'h81 + 8'(i));
    chk(burst_busy_r, 8'h00);
    host.wr(1'b0, 8'hff);
    for (int i = 0; i < 8; i++) view(3'(i), 8'h81 + 8'(i));
    host.wr(1'b1, 8'h20);
    view(3'h0, 8'h00);
    host.wr(1'b1, 8'h10);
    host.wr(1'b0, 8'h83);
    view(3'h0, 8'hcf);
    host.wr(1'b1, 8'h50);
    host.wr(1'b0, 8'h0a);
    view(3'h0, 8'h77);
    host.wr(1'b1, 8'h58);
    view(3'h0, 8'h86);
    host.wr(1'b1, 8'h10);
    view(3'h0, 8'h40);
    finish_test();
  end
endmodule
